// *** hw/pm_scale_defs.vh ***
// Constants shared by the power monitor result scaling design.
`ifndef PM_SCALE_DEFS_VH
`define PM_SCALE_DEFS_VH

// ----------------------------------------------------------------------
// Clock and conversion times
// ----------------------------------------------------------------------
`define PM_MCLK_MHZ      10
`define PM_CT0_US        50
`define PM_CT1_US        84
`define PM_CT2_US        150
`define PM_CT3_US        280
`define PM_CT4_US        540
`define PM_CT5_US        1052
`define PM_CT6_US        2074
`define PM_CT7_US        4120
`define PM_CT_CYC_W      16

// ----------------------------------------------------------------------
// Averaging counts as shift amounts (1, 4, 16, 64, 128, 256, 512, 1024)
// ----------------------------------------------------------------------
`define PM_AVG_SHIFT0    4'h0
`define PM_AVG_SHIFT1    4'h2
`define PM_AVG_SHIFT2    4'h4
`define PM_AVG_SHIFT3    4'h6
`define PM_AVG_SHIFT4    4'h7
`define PM_AVG_SHIFT5    4'h8
`define PM_AVG_SHIFT6    4'h9
`define PM_AVG_SHIFT7    4'hA
`define PM_AVG_CNT_W     11
`define PM_AVG_MAX_SHIFT 10

// ----------------------------------------------------------------------
// Result widths, scaling and limits
// ----------------------------------------------------------------------
`define PM_SHUNT_W       16
`define PM_BUS_W         16
`define PM_TEMP_W        12
`define PM_CAL_W         15
`define PM_POWER_W       24
`define PM_CUR_SHIFT     12
`define PM_POWER_SHIFT   8
`define PM_BUS_MAX_CODE  16'h6A40
`define PM_CUR_POS_MAX   32'sh00007FFF
`define PM_CUR_NEG_MIN   32'shFFFF8000
`define PM_CUR_RESET     16'h0000
`define PM_POWER_RESET   24'h000000

`endif

// *** hw/pm_conv_timer.v ***
// Conversion period divider: one-cycle tick at the end of each conversion.
`timescale 1ns/1ns
module pm_conv_timer #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          restart,
  input  wire [CW-1:0] len,
  output reg           tick
);

  reg [CW-1:0] cnt_q;

  // A restart reloads the full period so the first tick is a full one.
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= {CW{1'b0}};
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= len - {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end else if (cnt_q == {CW{1'b0}}) begin
      cnt_q <= len - {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule

// *** hw/pm_averager.v ***
// Signed accumulate-and-shift averager for one measurement channel.
`timescale 1ns/1ns
module pm_averager #(
  parameter W  = 16,
  parameter SW = 10
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                take,
  input  wire                first,
  input  wire                last,
  input  wire [3:0]          shift,
  input  wire signed [W-1:0] sample,
  output reg  signed [W-1:0] avg,
  output reg                 done
);

  reg  signed [W+SW-1:0] acc_q;
  wire signed [W+SW-1:0] sum;
  wire signed [W+SW-1:0] mean;

  assign sum  = (first ? {(W+SW){1'b0}} : acc_q)
                + {{SW{sample[W-1]}}, sample};
  assign mean = sum >>> shift;

  // The sample count is a power of two, so the mean is an arithmetic shift.
  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= {(W+SW){1'b0}};
      avg   <= {W{1'b0}};
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (take) begin
        acc_q <= sum;
        if (last) begin
          avg  <= mean[W-1:0];
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// *** hw/pm_result_scaler.v ***
// Result formatting, averaging and current and power derivation.
`timescale 1ns/1ns
`include "pm_scale_defs.vh"

// Notes on behaviour
// - Two shunt ranges, 5 or 1.25 uV steps.
// - Shunt result is 16-bit signed.
// - Bus result unsigned, 0 to 85 V, 3.125 mV.
// - Temperature result 12-bit signed, 125 mdegC.
// - Temperature code spans -256 to +255.875 degC.
// - New current after every shunt result, unless a settings change lands in the same cycle.
// - Zero calibration gives zero current.
// - Current counted in host-chosen current steps.
// - Power is unsigned 24-bit from current step.
// - Eight conversion times, 50 to 4120 us.
// - Averaging of conversions before results update.
// - Shunt limits share the shunt step weighting.
module pm_result_scaler #(
  parameter CONV_CYC_0 = `PM_CT0_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_1 = `PM_CT1_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_2 = `PM_CT2_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_3 = `PM_CT3_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_4 = `PM_CT4_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_5 = `PM_CT5_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_6 = `PM_CT6_US * `PM_MCLK_MHZ,
  parameter CONV_CYC_7 = `PM_CT7_US * `PM_MCLK_MHZ
) (
  input  wire                     MCLK,
  input  wire                     RST_N,
  input  wire                     SHUNT_RANGE_SELECT,
  input  wire [2:0]               CONV_TIME_SEL,
  input  wire [2:0]               AVG_SEL,
  input  wire [`PM_CAL_W-1:0]     SHUNT_CAL,
  input  wire [`PM_SHUNT_W-1:0]   SHUNT_OVER_LIMIT,
  input  wire [`PM_SHUNT_W-1:0]   SHUNT_UNDER_LIMIT,
  input  wire [`PM_SHUNT_W-1:0]   ADC_SHUNT_CODE,
  input  wire [`PM_BUS_W-1:0]     ADC_BUS_CODE,
  input  wire [`PM_TEMP_W-1:0]    ADC_TEMP_CODE,
  output reg                      ADC_RANGE_ACTIVE,
  output wire                     CONV_DONE,
  output reg  [`PM_SHUNT_W-1:0]   SHUNT_VOLTAGE_RESULT,
  output reg  [`PM_BUS_W-1:0]     BUS_VOLTAGE_RESULT,
  output reg  [`PM_TEMP_W-1:0]    DIE_TEMPERATURE_RESULT,
  output reg  [`PM_SHUNT_W-1:0]   CURRENT_RESULT,
  output reg  [`PM_POWER_W-1:0]   POWER_RESULT,
  output reg                      RESULT_READY,
  output reg                      SHUNT_OVER_FLAG,
  output reg                      SHUNT_UNDER_FLAG
);

  // --------------------------------------------------------------------
  // States and local sizes
  // --------------------------------------------------------------------
  localparam S_START   = 3'h0;
  localparam S_ACCUM   = 3'h1;
  localparam S_CURRENT = 3'h2;
  localparam S_POWER   = 3'h3;
  localparam S_PUBLISH = 3'h4;

  localparam CW = `PM_CT_CYC_W;
  localparam NW = `PM_AVG_CNT_W;

  reg  [2:0]               state_q;
  reg  [2:0]               state_d;
  reg                      range_q;
  reg  [2:0]               ct_sel_q;
  reg  [3:0]               shift_q;
  reg  [NW-1:0]            n_q;
  reg  [CW-1:0]            conv_len;
  reg  [3:0]               shift_sel;
  reg  [`PM_BUS_W-1:0]     bus_clamped;
  reg  signed [31:0]       prod_q;
  reg  [`PM_SHUNT_W-1:0]   cur_q;
  reg  [`PM_SHUNT_W-1:0]   cur_sat;
  reg  [`PM_POWER_W-1:0]   pwr_q;
  wire                     settings_changed;
  wire                     tick;
  wire                     first;
  wire                     last;
  wire                     sh_done;
  wire                     bus_done;
  wire                     tmp_done;
  wire signed [15:0]       sh_avg;
  wire signed [16:0]       bus_avg;
  wire signed [11:0]       tmp_avg;
  wire signed [15:0]       cal_s;
  wire signed [31:0]       cur_full;
  wire [15:0]              cur_mag;
  wire [31:0]              pwr_full;
  wire [NW-1:0]            n_last;

  // --------------------------------------------------------------------
  // Setting decode
  // --------------------------------------------------------------------
  always @* begin
    case (ct_sel_q)
      3'h0:    conv_len = CONV_CYC_0[CW-1:0];
      3'h1:    conv_len = CONV_CYC_1[CW-1:0];
      3'h2:    conv_len = CONV_CYC_2[CW-1:0];
      3'h3:    conv_len = CONV_CYC_3[CW-1:0];
      3'h4:    conv_len = CONV_CYC_4[CW-1:0];
      3'h5:    conv_len = CONV_CYC_5[CW-1:0];
      3'h6:    conv_len = CONV_CYC_6[CW-1:0];
      default: conv_len = CONV_CYC_7[CW-1:0];
    endcase
  end

  always @* begin
    case (AVG_SEL)
      3'h0:    shift_sel = `PM_AVG_SHIFT0;
      3'h1:    shift_sel = `PM_AVG_SHIFT1;
      3'h2:    shift_sel = `PM_AVG_SHIFT2;
      3'h3:    shift_sel = `PM_AVG_SHIFT3;
      3'h4:    shift_sel = `PM_AVG_SHIFT4;
      3'h5:    shift_sel = `PM_AVG_SHIFT5;
      3'h6:    shift_sel = `PM_AVG_SHIFT6;
      default: shift_sel = `PM_AVG_SHIFT7;
    endcase
  end

  // A block is never mixed across ranges or counts, but its first conversion runs for the time held before the
  // restart: any change throws the partial block away and starts over.
  assign settings_changed = (SHUNT_RANGE_SELECT != range_q) ||
                            (CONV_TIME_SEL != ct_sel_q) ||
                            (shift_sel != shift_q);

  // --------------------------------------------------------------------
  // Conversion timing and block counter
  // --------------------------------------------------------------------
  pm_conv_timer #(
    .CW      (CW)
  ) u_timer (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .restart (state_q == S_START),
    .len     (conv_len),
    .tick    (tick)
  );

  assign CONV_DONE = tick && (state_q != S_START);

  // One result every (conversion time x count) cycles.
  assign n_last = ({{(NW-1){1'b0}}, 1'b1} << shift_q)
                  - {{(NW-1){1'b0}}, 1'b1};
  assign first  = (n_q == {NW{1'b0}});
  assign last   = (n_q == n_last);

  always @(posedge MCLK) begin
    if (!RST_N) begin
      n_q <= {NW{1'b0}};
    end else if (state_q == S_START) begin
      n_q <= {NW{1'b0}};
    end else if (CONV_DONE) begin
      n_q <= last ? {NW{1'b0}} : n_q + {{(NW-1){1'b0}}, 1'b1};
    end
  end

  // --------------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------------
  // Bus codes above 85 V full scale are clamped to full scale.
  always @* begin
    if (ADC_BUS_CODE > `PM_BUS_MAX_CODE) begin
      bus_clamped = `PM_BUS_MAX_CODE;
    end else begin
      bus_clamped = ADC_BUS_CODE;
    end
  end

  // --------------------------------------------------------------------
  // Per-channel averaging
  // --------------------------------------------------------------------
  pm_averager #(
    .W      (`PM_SHUNT_W),
    .SW     (`PM_AVG_MAX_SHIFT)
  ) u_avg_shunt (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .take   (CONV_DONE),
    .first  (first),
    .last   (last),
    .shift  (shift_q),
    .sample (ADC_SHUNT_CODE),
    .avg    (sh_avg),
    .done   (sh_done)
  );

  // Bus codes are unsigned, so a zero sign bit is added for the averager.
  pm_averager #(
    .W      (`PM_BUS_W + 1),
    .SW     (`PM_AVG_MAX_SHIFT)
  ) u_avg_bus (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .take   (CONV_DONE),
    .first  (first),
    .last   (last),
    .shift  (shift_q),
    .sample ({1'b0, bus_clamped}),
    .avg    (bus_avg),
    .done   (bus_done)
  );

  pm_averager #(
    .W      (`PM_TEMP_W),
    .SW     (`PM_AVG_MAX_SHIFT)
  ) u_avg_temp (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .take   (CONV_DONE),
    .first  (first),
    .last   (last),
    .shift  (shift_q),
    .sample (ADC_TEMP_CODE),
    .avg    (tmp_avg),
    .done   (tmp_done)
  );

  // --------------------------------------------------------------------
  // Current and power arithmetic
  // --------------------------------------------------------------------
  assign cal_s    = {1'b0, SHUNT_CAL};
  assign cur_full = prod_q >>> `PM_CUR_SHIFT;
  assign cur_mag  = cur_q[15] ? (~cur_q + 16'h0001) : cur_q;
  assign pwr_full = cur_mag * BUS_VOLTAGE_RESULT;

  // Saturate to the signed 16-bit current range.
  always @* begin
    if (SHUNT_CAL == {`PM_CAL_W{1'b0}}) begin
      cur_sat = `PM_CUR_RESET;
    end else if (cur_full > `PM_CUR_POS_MAX) begin
      cur_sat = 16'h7FFF;
    end else if (cur_full < `PM_CUR_NEG_MIN) begin
      cur_sat = 16'h8000;
    end else begin
      cur_sat = cur_full[15:0];
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      S_START: begin
        state_d = S_ACCUM;
      end
      S_ACCUM: begin
        if (settings_changed) begin
          state_d = S_START;
        end else if (sh_done && bus_done && tmp_done) begin
          state_d = S_CURRENT;
        end
      end
      S_CURRENT: begin
        state_d = S_POWER;
      end
      S_POWER: begin
        state_d = S_PUBLISH;
      end
      default: begin
        state_d = settings_changed ? S_START : S_ACCUM;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (!RST_N) begin
      state_q          <= S_START;
      range_q          <= 1'b0;
      ct_sel_q         <= 3'h0;
      shift_q          <= `PM_AVG_SHIFT0;
      ADC_RANGE_ACTIVE <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == S_START) begin
        range_q          <= SHUNT_RANGE_SELECT;
        ct_sel_q         <= CONV_TIME_SEL;
        shift_q          <= shift_sel;
        ADC_RANGE_ACTIVE <= SHUNT_RANGE_SELECT;
      end
    end
  end

  // --------------------------------------------------------------------
  // Result registers
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (!RST_N) begin
      SHUNT_VOLTAGE_RESULT   <= {`PM_SHUNT_W{1'b0}};
      BUS_VOLTAGE_RESULT     <= {`PM_BUS_W{1'b0}};
      DIE_TEMPERATURE_RESULT <= {`PM_TEMP_W{1'b0}};
      prod_q                 <= 32'sh00000000;
      cur_q                  <= `PM_CUR_RESET;
      pwr_q                  <= `PM_POWER_RESET;
      CURRENT_RESULT         <= `PM_CUR_RESET;
      POWER_RESULT           <= `PM_POWER_RESET;
      RESULT_READY           <= 1'b0;
      SHUNT_OVER_FLAG        <= 1'b0;
      SHUNT_UNDER_FLAG       <= 1'b0;
    end else begin
      RESULT_READY <= 1'b0;
      if (state_q == S_ACCUM && sh_done) begin
        SHUNT_VOLTAGE_RESULT   <= sh_avg;
        BUS_VOLTAGE_RESULT     <= bus_avg[`PM_BUS_W-1:0];
        DIE_TEMPERATURE_RESULT <= tmp_avg;
        prod_q                 <= sh_avg * cal_s;
      end
      if (state_q == S_CURRENT) begin
        cur_q <= cur_sat;
      end
      if (state_q == S_POWER) begin
        pwr_q <= pwr_full[`PM_POWER_SHIFT+`PM_POWER_W-1:
                          `PM_POWER_SHIFT];
      end
      if (state_q == S_PUBLISH) begin
        CURRENT_RESULT   <= cur_q;
        POWER_RESULT     <= pwr_q;
        RESULT_READY     <= 1'b1;
        SHUNT_OVER_FLAG  <= ($signed(SHUNT_VOLTAGE_RESULT) >
                             $signed(SHUNT_OVER_LIMIT));
        SHUNT_UNDER_FLAG <= ($signed(SHUNT_VOLTAGE_RESULT) <
                             $signed(SHUNT_UNDER_LIMIT));
      end
    end
  end

endmodule

// *** verification/pm_scale_asserts.sv ***
// Concurrent checks on the ports of the result scaling block.
`timescale 1ns/1ns
module pm_scale_asserts #(
  parameter CONV_CYC_0 = 500
) (
  input wire        MCLK,
  input wire        RST_N,
  input wire [14:0] SHUNT_CAL,
  input wire [15:0] SHUNT_OVER_LIMIT,
  input wire        CONV_DONE,
  input wire [15:0] SHUNT_VOLTAGE_RESULT,
  input wire [15:0] BUS_VOLTAGE_RESULT,
  input wire [15:0] CURRENT_RESULT,
  input wire [23:0] POWER_RESULT,
  input wire        RESULT_READY,
  input wire        SHUNT_OVER_FLAG
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ------------------------------------------------------------------
  // Cycles since the last conversion pulse
  // ------------------------------------------------------------------
  reg [15:0] gap_q;
  reg        seen_q;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (CONV_DONE) begin
      gap_q  <= 16'h0001;
      seen_q <= 1'b1;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  a_done_pulse: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("conversion pulse longer than one cycle");
  a_conv_spacing: assert property (
      CONV_DONE && seen_q |-> gap_q >= CONV_CYC_0)
    else $error("conversions closer than the shortest time");
  a_ready_pulse: assert property (RESULT_READY |=> !RESULT_READY)
    else $error("result pulse longer than one cycle");
  a_current_hold: assert property (
      $changed(CURRENT_RESULT) |-> RESULT_READY)
    else $error("current changed without a result pulse");
  a_power_hold: assert property (
      $changed(POWER_RESULT) |-> RESULT_READY)
    else $error("power changed without a result pulse");
  a_bus_clamp: assert property (BUS_VOLTAGE_RESULT <= 16'h6A40)
    else $error("bus result above full scale");
  a_cal_zero: assert property (
      RESULT_READY && SHUNT_CAL == 15'h0000 &&
      $past(SHUNT_CAL, 5) == 15'h0000 |-> CURRENT_RESULT == 16'h0000)
    else $error("current not zero with zero calibration");
  a_sign_follow: assert property (
      RESULT_READY && CURRENT_RESULT != 16'h0000
      |-> CURRENT_RESULT[15] == SHUNT_VOLTAGE_RESULT[15])
    else $error("current sign differs from shunt sign");
  a_power_zero: assert property (
      RESULT_READY && CURRENT_RESULT == 16'h0000
      |-> POWER_RESULT == 24'h000000)
    else $error("power not zero with zero current");
  a_over_flag: assert property (RESULT_READY &&
      $past(SHUNT_OVER_LIMIT, 4) == SHUNT_OVER_LIMIT |-> SHUNT_OVER_FLAG ==
      ($signed(SHUNT_VOLTAGE_RESULT) > $signed(SHUNT_OVER_LIMIT)))
    else $error("over flag disagrees with shunt result");
endmodule

bind pm_result_scaler pm_scale_asserts #(.CONV_CYC_0(CONV_CYC_0)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .SHUNT_CAL(SHUNT_CAL),
  .SHUNT_OVER_LIMIT(SHUNT_OVER_LIMIT), .CONV_DONE(CONV_DONE),
  .SHUNT_VOLTAGE_RESULT(SHUNT_VOLTAGE_RESULT),
  .BUS_VOLTAGE_RESULT(BUS_VOLTAGE_RESULT), .CURRENT_RESULT(CURRENT_RESULT),
  .POWER_RESULT(POWER_RESULT), .RESULT_READY(RESULT_READY),
  .SHUNT_OVER_FLAG(SHUNT_OVER_FLAG));

// *** verification/pm_host_model.sv ***
// Host controller model that works out the calibration constant.
`timescale 1ns/1ns
module pm_host_model #(
  parameter real MAX_AMPS  = 10.0,
  parameter real RSHUNT    = 0.002,
  parameter real STEP_MULT = 1.0
) (
  input  wire logic        range_sel,
  output logic      [14:0] cal
);
  real step;
  // ------------------------------------------------------------------
  // Step size is the minimum times STEP_MULT, with no limit applied
  // ------------------------------------------------------------------
  always_comb begin
    step = MAX_AMPS / 32768.0 * STEP_MULT;
    cal  = 15'($rtoi(819.2e6 * step * RSHUNT *
           (range_sel ? 4.0 : 1.0) + 0.5));
  end
endmodule

// *** verification/pm_result_scaler_tb.sv ***
// Self-checking testbench for the result scaling block.
`timescale 1ns/1ns
`include "pm_scale_defs.vh"
module pm_result_scaler_tb;
  localparam int CC[8] = '{8, 10, 12, 14, 16, 18, 20, 22};
  localparam int AS[8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        rng = 1'b0;
  logic [2:0]  ct = 3'h0;
  logic [2:0]  av = 3'h0;
  logic        cal_zero = 1'b0;
  logic [15:0] ovl = 16'h7FFF;
  logic [15:0] uvl = 16'h8000;
  logic [15:0] sh = 16'h0000;
  logic [15:0] bu = 16'h0000;
  logic [11:0] tp = 12'h000;
  logic [14:0] host_cal;
  logic [14:0] cal;
  wire         rng_act, conv_done, rdy, ovf, unf;
  wire  [15:0] sv, bv, cr;
  wire  [11:0] dt;
  wire  [23:0] pw;
  int          num_errors = 0;
  int          compares = 0;
  assign cal = cal_zero ? 15'h0000 : host_cal;
  always #50 MCLK = ~MCLK;
  pm_host_model host (.range_sel(rng), .cal(host_cal));
  pm_result_scaler #(.CONV_CYC_0(CC[0]), .CONV_CYC_1(CC[1]),
    .CONV_CYC_2(CC[2]), .CONV_CYC_3(CC[3]), .CONV_CYC_4(CC[4]),
    .CONV_CYC_5(CC[5]), .CONV_CYC_6(CC[6]), .CONV_CYC_7(CC[7])) uut (
    .MCLK(MCLK), .RST_N(RST_N), .SHUNT_RANGE_SELECT(rng),
    .CONV_TIME_SEL(ct), .AVG_SEL(av), .SHUNT_CAL(cal),
    .SHUNT_OVER_LIMIT(ovl), .SHUNT_UNDER_LIMIT(uvl), .ADC_SHUNT_CODE(sh),
    .ADC_BUS_CODE(bu), .ADC_TEMP_CODE(tp), .ADC_RANGE_ACTIVE(rng_act),
    .CONV_DONE(conv_done), .SHUNT_VOLTAGE_RESULT(sv),
    .BUS_VOLTAGE_RESULT(bv), .DIE_TEMPERATURE_RESULT(dt),
    .CURRENT_RESULT(cr), .POWER_RESULT(pw), .RESULT_READY(rdy),
    .SHUNT_OVER_FLAG(ovf), .SHUNT_UNDER_FLAG(unf));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rr(output int n);
    n = 0;
    do begin
      @(negedge MCLK);
      n++;
    end while (rdy !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // The second result after a change is the first one built wholly from it.
  task automatic run(input logic r, input logic [2:0] a,
                     input logic [15:0] s, b, input logic [11:0] t);
    int          n;
    longint      p;
    logic [15:0] e_b;
    logic [15:0] e_c;
    @(negedge MCLK);
    rng = r;
    av = a;
    sh = s;
    bu = b;
    tp = t;
    wait_rr(n);
    wait_rr(n);
    e_b = (b > `PM_BUS_MAX_CODE) ? `PM_BUS_MAX_CODE : b;
    p = ($signed(s) * longint'(cal)) >>> `PM_CUR_SHIFT;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    e_c = 16'(p);
    chk(sv, s);
    chk(bv, e_b);
    chk(dt, t);
    chk(cr, e_c);
    p = $signed(e_c);
    if (p < 0) p = -p;
    chk(pw, 24'((p * e_b) >> `PM_POWER_SHIFT));
    chk(rng_act, r);
    chk(ovf, $signed(s) > $signed(ovl));
    chk(unf, $signed(s) < $signed(uvl));
  endtask
  task automatic period(input logic [2:0] c, input logic [2:0] a);
    int n;
    @(negedge MCLK);
    ct = c;
    av = a;
    wait_rr(n);
    wait_rr(n);
    chk(n, CC[c] << AS[a]);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_format;
    ovl = 16'h0800;
    uvl = 16'h8000;
    run(1'b0, 3'h0, 16'h1000, 16'h2000, 12'hF80);
    ovl = 16'h7FFF;
    uvl = 16'h0000;
    run(1'b0, 3'h0, 16'hF000, 16'hFFFF, 12'h800);
    run(1'b0, 3'h0, 16'h8000, 16'h6A40, 12'h7FF);
    $display("t_format done");
  endtask
  task automatic t_cal_zero;
    cal_zero = 1'b1;
    run(1'b0, 3'h0, 16'h1000, 16'h2000, 12'h010);
    cal_zero = 1'b0;
    $display("t_cal_zero done");
  endtask
  task automatic t_range;
    run(1'b1, 3'h0, 16'hFC00, 16'h1000, 12'h010);
    run(1'b0, 3'h1, 16'h0400, 16'h1000, 12'h010);
    $display("t_range done");
  endtask
  task automatic t_average;
    run(1'b0, 3'h2, 16'hFFFD, 16'h0100, 12'hFFF);
    $display("t_average done");
  endtask
  task automatic t_period;
    for (int i = 0; i < 8; i++) period(3'(i), 3'h0);
    for (int i = 1; i < 8; i++) period(3'h0, 3'(i));
    $display("t_period done");
  endtask
  initial begin
    repeat (8) @(negedge MCLK);
    RST_N = 1'b1;
    @(negedge MCLK);
    chk(rdy, 1'b0);
    chk(cr, 16'h0000);
    chk(pw, 24'h000000);
    t_format();
    t_cal_zero();
    t_range();
    t_average();
    t_period();
    give_verdict();
  end
endmodule
